// ===== core/scl_deglitch.sv
`timescale 1ns/10ps
module scl_deglitch #(
	parameter int CNT_W = 10
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             ce,
	input  wire logic [CNT_W-1:0] limit,
	input  wire logic             raw,
	output logic                  filtered
);
	logic [CNT_W-1:0] count;
	logic [CNT_W:0]   next_count;

	if (CNT_W < 1) begin : g_check
		$error("scl_deglitch: CNT_W must be at least 1");
	end

	assign next_count = {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};

	// ====================================================================
	// filter: level must differ on limit consecutive samples, on one sample when limit is zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count    <= '0;
			filtered <= 1'b0;
		end else if (ce) begin
			if (raw == filtered) begin
				count <= '0;
			end else if (next_count >= {1'b0, limit}) begin
				filtered <= raw;
				count    <= '0;
			end else begin
				count <= next_count[CNT_W-1:0];
			end
		end
	end

	// ====================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	pass_through_a: assert property (ce && limit == '0 |=> filtered == $past(raw))
		else $error("zero deglitch code did not pass the level");
	early_change_a: assert property (ce && raw != filtered && next_count < {1'b0, limit} |=> $stable(filtered))
		else $error("level passed before the deglitch time elapsed");
	late_change_a: assert property (ce && raw != filtered && next_count >= {1'b0, limit} |=> filtered == $past(raw))
		else $error("stable level not passed after the deglitch time");
	glitch_drop_a: assert property (ce && raw == filtered |=> $stable(filtered) && count == '0)
		else $error("matching level disturbed the filter");

endmodule

// ===== core/scl_pkg.sv
package scl_pkg;

	// ====================================================================
	// timing
	localparam int CLK_MHZ     = 100;
	localparam int STEP_NS     = 640;
	localparam int MAX_NS      = 9600;
	// least time: round up to whole cycles
	localparam int STEP_CYCLES = (STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int CODE_W      = 4;
	localparam int CNT_W       = 10;

	// ====================================================================
	// register map (offsets are word indices, byte address is four times the index)
	localparam logic [31:0] SETUP_INDEX  = 32'h0000_0014;
	localparam logic [31:0] STATUS_INDEX = 32'h0000_001F;
	localparam logic [15:0] SETUP_RESET  = 16'h0000;

	localparam int DEGLITCH_LSB    = 0;
	localparam int INHIBIT_BIT     = 4;
	localparam int GATING_LSB      = 5;
	localparam int SETUP_USED_BITS = 7;

	localparam int STATUS_HALL_LSB = 0;
	localparam int STATUS_OTS_BIT  = 8;
	localparam int STATUS_AMP_LSB  = 16;

	localparam logic [1:0] GATE_LOW_HIGH = 2'h0;
	localparam logic [1:0] GATE_HIGH_LOW = 2'h1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ====================================================================
	// carriers
	typedef struct packed {
		logic [1:0]        amp_output_gating_select;
		logic              overtemp_shutdown_inhibit;
		logic [CODE_W-1:0] deglitch_code;
	} scl_setup_type;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} scl_axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} scl_axi_rsp_type;

	// ====================================================================
	// helpers
	function automatic logic [CNT_W-1:0] scl_deglitch_cycles(input logic [CODE_W-1:0] code);
		return CNT_W'(32'(code) * STEP_CYCLES);
	endfunction

	function automatic logic [29:0] scl_word_index(input logic [31:0] addr);
		return addr[31:2];
	endfunction

endpackage

// ===== core/scl_top.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module scl_top #(
	parameter int HALL_COUNT  = 3,
	parameter int PHASE_COUNT = 3
) (
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic                       ce,
	input  wire scl_pkg::scl_axi_req_type   axi_req,
	output scl_pkg::scl_axi_rsp_type        axi_rsp,
	input  wire logic [HALL_COUNT-1:0]      hall_raw,
	output logic      [HALL_COUNT-1:0]      hall_filtered,
	input  wire logic                       overtemp_detect,
	output logic                            overtemp_shutdown,
	input  wire logic [PHASE_COUNT-1:0]     low_side_gate_drive,
	input  wire logic [PHASE_COUNT-1:0]     high_side_gate_drive,
	output logic      [PHASE_COUNT-1:0]     amp_output_enable
);
	import scl_pkg::*;

	if (HALL_COUNT < 1 || HALL_COUNT > STATUS_OTS_BIT - STATUS_HALL_LSB) begin : g_hall_check
		$error("scl_top: HALL_COUNT out of range");
	end
	if (PHASE_COUNT < 1 || PHASE_COUNT > 32 - STATUS_AMP_LSB) begin : g_phase_check
		$error("scl_top: PHASE_COUNT out of range");
	end

	scl_setup_type    setup;
	logic [CNT_W-1:0] deglitch_limit;

	logic        aw_held;
	logic [31:0] aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        rvalid;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        awready;
	logic        wready;
	logic        arready;
	logic        do_write;
	logic        write_setup;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic [31:0] status_word;

	// ====================================================================
	// bus handshake
	assign awready  = ce && !aw_held;
	assign wready   = ce && !w_held;
	assign arready  = ce && !rvalid;
	// one write in flight: response must drain before the next commits
	assign do_write = ce && aw_held && w_held && !bvalid;
	assign write_setup = do_write && scl_word_index(aw_addr) == SETUP_INDEX[29:0];

	always_comb begin
		axi_rsp         = '0;
		axi_rsp.awready = awready;
		axi_rsp.wready  = wready;
		axi_rsp.bvalid  = bvalid;
		axi_rsp.bresp   = bresp;
		axi_rsp.arready = arready;
		axi_rsp.rvalid  = rvalid;
		axi_rsp.rdata   = rdata;
		axi_rsp.rresp   = rresp;
	end

	// ====================================================================
	// write address / data capture, either order
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
		end else if (ce) begin
			if (axi_req.awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= axi_req.awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (ce) begin
			if (axi_req.wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= axi_req.wdata;
				w_strb <= axi_req.wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				bvalid <= 1'b1;
				if (scl_word_index(aw_addr) == SETUP_INDEX[29:0] ||
				    scl_word_index(aw_addr) == STATUS_INDEX[29:0]) begin
					bresp <= RESP_OKAY;
				end else begin
					bresp <= RESP_SLVERR;
				end
			end else if (axi_req.bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ====================================================================
	// sensing setup register, only byte lane 0 holds live bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			setup <= scl_setup_type'(SETUP_RESET[SETUP_USED_BITS-1:0]);
		end else if (ce && write_setup && w_strb[0]) begin
			setup <= scl_setup_type'(w_data[SETUP_USED_BITS-1:0]);
		end
	end

	// ====================================================================
	// read path
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STATUS_HALL_LSB +: HALL_COUNT]  = hall_filtered;
		status_word[STATUS_OTS_BIT]                  = overtemp_shutdown;
		status_word[STATUS_AMP_LSB +: PHASE_COUNT]  = amp_output_enable;
		next_rdata = 32'h0000_0000;
		next_rresp = RESP_OKAY;
		if (scl_word_index(axi_req.araddr) == SETUP_INDEX[29:0]) begin
			next_rdata[SETUP_USED_BITS-1:0] = setup;
		end else if (scl_word_index(axi_req.araddr) == STATUS_INDEX[29:0]) begin
			next_rdata = status_word;
		end else begin
			next_rresp = RESP_SLVERR;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (axi_req.arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= next_rdata;
				rresp  <= next_rresp;
			end else if (axi_req.rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ====================================================================
	// hall deglitch
	assign deglitch_limit = scl_deglitch_cycles(setup.deglitch_code);

	for (genvar i = 0; i < HALL_COUNT; i++) begin : g_hall
		scl_deglitch #(
			.CNT_W (CNT_W)
		) u_deglitch (
			.clk      (clk),
			.reset_n  (reset_n),
			.ce       (ce),
			.limit    (deglitch_limit),
			.raw      (hall_raw[i]),
			.filtered (hall_filtered[i])
		);
	end

	// ====================================================================
	// over-temperature shutdown
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			overtemp_shutdown <= 1'b0;
		end else if (ce) begin
			overtemp_shutdown <= overtemp_detect && !setup.overtemp_shutdown_inhibit;
		end
	end

	// ====================================================================
	// amplifier output gating, registered so outputs never glitch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			amp_output_enable <= '0;
		end else if (ce) begin
			if (setup.amp_output_gating_select[1]) begin
				amp_output_enable <= '1;
			end else if (setup.amp_output_gating_select == GATE_HIGH_LOW) begin
				amp_output_enable <= ~high_side_gate_drive;
			end else begin
				amp_output_enable <= low_side_gate_drive;
			end
		end
	end

	// ====================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence read_setup_taken;
		ce && axi_req.arvalid && arready && scl_word_index(axi_req.araddr) == SETUP_INDEX[29:0];
	endsequence

	sequence write_pair_ready;
		ce && aw_held && w_held && !bvalid;
	endsequence

	ots_follow_a: assert property (ce |=> overtemp_shutdown ==
		($past(overtemp_detect) && !$past(setup.overtemp_shutdown_inhibit)))
		else $error("shutdown does not follow detect and inhibit");
	gate_low_a: assert property (ce && setup.amp_output_gating_select == GATE_LOW_HIGH
		|=> amp_output_enable == $past(low_side_gate_drive))
		else $error("amplifier gating by low-side drive wrong");
	gate_high_a: assert property (ce && setup.amp_output_gating_select == GATE_HIGH_LOW
		|=> amp_output_enable == ~$past(high_side_gate_drive))
		else $error("amplifier gating by high-side drive wrong");
	always_on_a: assert property (ce && setup.amp_output_gating_select[1] [*2]
		|-> amp_output_enable == '1)
		else $error("amplifier outputs not always active");
	read_zero_a: assert property (read_setup_taken |=> rvalid && rdata[31:SETUP_USED_BITS] == '0
		&& rdata[SETUP_USED_BITS-1:0] == $past(setup))
		else $error("setup readback wrong or upper bits not zero");
	write_resp_a: assert property (write_pair_ready |=> bvalid && !aw_held && !w_held)
		else $error("write response not raised after both halves held");
	setup_load_a: assert property (ce && write_setup && w_strb[0]
		|=> setup == $past(w_data[SETUP_USED_BITS-1:0]) && deglitch_limit ==
		scl_deglitch_cycles($past(w_data[CODE_W-1:0])))
		else $error("setup write did not steer deglitch limit");

endmodule

// ===== verif/scl_hall_model.sv
`timescale 1ns/10ps
// ====================
// hall sensors: levels move only just after a rising edge
module scl_hall_model #(
	parameter int N = 3
) (
	input  wire logic         clk,
	output logic      [N-1:0] hall
);
	initial hall = '0;
	task automatic put(input logic [N-1:0] v);
		@(posedge clk);
		hall <= v;
	endtask
endmodule

// ===== verif/scl_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, a); end end
module scl_tb_top;
	import scl_pkg::*;
	localparam logic [31:0] SETUP_ADDR = {SETUP_INDEX[29:0], 2'b00};
	localparam logic [31:0] STAT_ADDR  = {STATUS_INDEX[29:0], 2'b00};
	logic            clk;
	logic            reset_n;
	logic            ce;
	logic            otd;
	logic            ots;
	logic [2:0]      low;
	logic [2:0]      high;
	logic [2:0]      hall;
	logic [2:0]      hf;
	logic [2:0]      amp;
	logic [2:0]      cur;
	logic [31:0]     rd;
	logic [1:0]      rs;
	int              lim;
	int              fail_count;
	int              n_checks;
	scl_axi_req_type req;
	scl_axi_rsp_type rsp;

	scl_hall_model scl_hall_model_i (.clk(clk), .hall(hall));
	scl_top scl_top_i (.clk(clk), .reset_n(reset_n), .ce(ce), .axi_req(req), .axi_rsp(rsp),
		.hall_raw(hall), .hall_filtered(hf), .overtemp_detect(otd), .overtemp_shutdown(ots),
		.low_side_gate_drive(low), .high_side_gate_drive(high), .amp_output_enable(amp));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ====================
	// bus master: payload held until its own ready, answer taken at that edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic aw, w, b;
		@(posedge clk);
		req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
		req.wdata <= d; req.wstrb <= 4'hF; req.bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			aw = rsp.awready & req.awvalid; w = rsp.wready & req.wvalid; b = rsp.bvalid; rs = rsp.bresp;
			@(posedge clk);
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
		end
		req.bready <= 1'b0;
	endtask

	task automatic rdw(input logic [31:0] a);
		logic ar, r;
		@(posedge clk);
		req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge clk);
			ar = rsp.arready & req.arvalid; r = rsp.rvalid; rd = rsp.rdata; rs = rsp.rresp;
			@(posedge clk);
			if (ar) req.arvalid <= 1'b0;
		end
		req.rready <= 1'b0;
	endtask

	task automatic end_of_test;
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard at 10000 cycles, far beyond the fewer than 1500 cycles the tests need
	initial begin
		#100us;
		fail_count++;
		end_of_test();
	end

	initial begin
		reset_n = 1'b0; ce = 1'b1; otd = 1'b0; low = '0; high = '0; req = '0;
		fail_count = 0; n_checks = 0; cur = '0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rdw(SETUP_ADDR);
		`CHK("setup reset", 32'h0000_0000, rd)
		wr(SETUP_ADDR, 32'hFFFF_FFFF);
		`CHK("setup wr resp", RESP_OKAY, rs)
		rdw(SETUP_ADDR);
		`CHK("setup upper", 32'h0000_007F, rd)
		rdw(32'h0000_0040);
		`CHK("unmapped resp", RESP_SLVERR, rs)
		// ====================
		// deglitch: short pulse dropped, step passes after exactly the limit
		for (int i = 0; i < 3; i++) begin
			lim = (i == 0) ? 1 : ((i == 1) ? 1 : 15) * STEP_CYCLES;
			wr(SETUP_ADDR, (i == 0) ? 32'h0 : ((i == 1) ? 32'h1 : 32'hF));
			if (i == 1) begin
				scl_hall_model_i.put(~cur);
				repeat (lim - 2) @(posedge clk);
				scl_hall_model_i.put(cur);
				repeat (lim + 4) @(negedge clk);
				`CHK("hall pulse", cur, hf)
			end
			cur = ~cur;
			scl_hall_model_i.put(cur);
			// last cycle before the limit, then the first one after it
			repeat (lim) @(negedge clk);
			`CHK("hall early", ~cur, hf)
			@(negedge clk);
			`CHK("hall late", cur, hf)
		end
		// ====================
		// over-temperature: inhibit bit gates the shutdown
		wr(SETUP_ADDR, 32'h0);
		otd <= 1'b1;
		repeat (3) @(negedge clk);
		`CHK("shutdown on", 1'b1, ots)
		rdw(STAT_ADDR);
		`CHK("status ots", 1'b1, rd[STATUS_OTS_BIT])
		// clock enable low must freeze the shutdown output
		@(posedge clk);
		ce <= 1'b0;
		otd <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK("frozen ots", 1'b1, ots)
		@(posedge clk);
		ce <= 1'b1;
		otd <= 1'b1;
		wr(SETUP_ADDR, 32'h10);
		repeat (3) @(negedge clk);
		`CHK("shutdown off", 1'b0, ots)
		// ====================
		// amplifier gating, every select code
		@(posedge clk);
		low <= 3'b101;
		high <= 3'b110;
		for (int m = 0; m < 4; m++) begin
			wr(SETUP_ADDR, 32'(m) << GATING_LSB);
			repeat (3) @(negedge clk);
			`CHK("amp enable", (m == 0) ? 3'b101 : ((m == 1) ? 3'b001 : 3'b111), amp)
		end
		@(posedge clk);
		low <= 3'b010;
		high <= 3'b001;
		repeat (3) @(negedge clk);
		`CHK("amp always", 3'b111, amp)
		rdw(STAT_ADDR);
		`CHK("status amp", 3'b111, rd[STATUS_AMP_LSB +: 3])
		`CHK("status hall", cur, rd[STATUS_HALL_LSB +: 3])
		end_of_test();
	end
endmodule
